/* verilog/dlt_pkg.sv */
// Shared constants, register map and carrier types for the dual legacy timer pair.
package dlt_pkg;

  // Special-function register addresses.
  localparam logic [7:0] DLT_ADDR_CTRL = 8'h88;
  localparam logic [7:0] DLT_ADDR_MODE = 8'h89;
  localparam logic [7:0] DLT_ADDR_T0_LOW = 8'h8A;
  localparam logic [7:0] DLT_ADDR_T1_LOW = 8'h8B;
  localparam logic [7:0] DLT_ADDR_T0_HIGH = 8'h8C;
  localparam logic [7:0] DLT_ADDR_T1_HIGH = 8'h8D;
  localparam logic [7:0] DLT_ADDR_CLKSEL = 8'h8E;

  // Field positions in timer_control.
  localparam int DLT_CTRL_OVF1 = 7;
  localparam int DLT_CTRL_RUN1 = 6;
  localparam int DLT_CTRL_OVF0 = 5;
  localparam int DLT_CTRL_RUN0 = 4;
  localparam int DLT_CTRL_EXT1_FLAG = 3;
  localparam int DLT_CTRL_EXT1_TYPE = 2;
  localparam int DLT_CTRL_EXT0_FLAG = 1;
  localparam int DLT_CTRL_EXT0_TYPE = 0;

  // Field positions in timer_clock_select.
  localparam int DLT_CKS_CLK1 = 4;
  localparam int DLT_CKS_CLK0 = 3;
  localparam int DLT_CKS_PRESC_LSB = 0;
  localparam logic [7:0] DLT_CKS_WR_MASK = 8'h1B;

  // Value of every register after reset.
  localparam logic [7:0] DLT_RESET_BYTE = 8'h00;

  // Prescaler divisors, as terminal counts of a 6-bit divider.
  localparam logic [5:0] DLT_DIV_12 = 6'h0C;
  localparam logic [5:0] DLT_DIV_4 = 6'h04;
  localparam logic [5:0] DLT_DIV_48 = 6'h30;
  localparam logic [5:0] DLT_DIV_EXT_8 = 6'h08;

  typedef enum logic [1:0] {
    DLT_MODE_13BIT = 2'b00,
    DLT_MODE_16BIT = 2'b01,
    DLT_MODE_RELOAD = 2'b10,
    DLT_MODE_SPLIT = 2'b11
  } dlt_mode_t;

  typedef enum logic [1:0] {
    DLT_PRESC_SYS_12 = 2'b00,
    DLT_PRESC_SYS_4 = 2'b01,
    DLT_PRESC_SYS_48 = 2'b10,
    DLT_PRESC_EXT_8 = 2'b11
  } dlt_presc_t;

  // One nibble of timer_mode_select; the register is {timer one, timer zero}.
  typedef struct packed {
    logic gate;
    logic counter_sel;
    dlt_mode_t mode;
  } dlt_tcfg_t;

  // Result of one count step of a timer.
  typedef struct packed {
    logic ovf;
    logic [7:0] hi;
    logic [7:0] lo;
  } dlt_cnt_t;

endpackage

/* verilog/dlt_edge_det.sv */
// Falling and rising edge detector for a group of synchronous pin levels.
`timescale 1ns/100ps
module dlt_edge_det #(
  parameter int N = 5
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Levels and edges
  input wire logic [N-1:0] level_i,
  output logic [N-1:0] fall_o,
  output logic [N-1:0] rise_o
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      logic prev_r;
      // Starting high keeps a pin that is high at reset from faking a rise.
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          prev_r <= 1'b1;
        end else begin
          prev_r <= level_i[g];
        end
      end
      assign fall_o[g] = prev_r & ~level_i[g];
      assign rise_o[g] = ~prev_r & level_i[g];
    end
  endgenerate
endmodule // dlt_edge_det

/* verilog/dlt_prescaler.sv */
// Prescaled clock tick generator for the timer pair.
`timescale 1ns/100ps
module dlt_prescaler
  import dlt_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Control
  input wire dlt_presc_t code_i,
  input wire logic ext_rise_i,
  // Tick
  output logic tick_o
);
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic [5:0] div;
  logic step;

  always_comb begin
    div = DLT_DIV_12;
    step = 1'b1;
    case (code_i)
      DLT_PRESC_SYS_12: div = DLT_DIV_12;
      DLT_PRESC_SYS_4: div = DLT_DIV_4;
      DLT_PRESC_SYS_48: div = DLT_DIV_48;
      DLT_PRESC_EXT_8: begin
        div = DLT_DIV_EXT_8;
        step = ext_rise_i;
      end
      default: div = DLT_DIV_12;
    endcase
  end

  // A code change leaves the count running; the first tick after it may come early.
  assign tick_o = step & (cnt_r >= div - 6'h01);
  assign cnt_nxt = tick_o ? 6'h00 : (step ? cnt_r + 6'h01 : cnt_r);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r <= 6'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule // dlt_prescaler

/* verilog/dlt_timer_pair.sv */
// Dual legacy counter/timer pair with control, mode and clock-select registers.
`timescale 1ns/100ps
module dlt_timer_pair
  import dlt_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  // Special-function register port
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic [7:0] SFR_WDATA_I,
  output logic [7:0] SFR_RDATA_O,
  // Interrupt vector acknowledges
  input wire logic TMR0_VECTOR_I,
  input wire logic TMR1_VECTOR_I,
  input wire logic EXT0_VECTOR_I,
  input wire logic EXT1_VECTOR_I,
  // Pins
  input wire logic EVENT_PIN_ZERO_I,
  input wire logic EVENT_PIN_ONE_I,
  input wire logic GATE_PIN_ZERO_N_I,
  input wire logic GATE_PIN_ONE_N_I,
  input wire logic EXT_CLK_I,
  // Interrupt requests and overflow trigger
  output logic TMR0_IRQ_O,
  output logic TMR1_IRQ_O,
  output logic EXT0_IRQ_O,
  output logic EXT1_IRQ_O,
  output logic TMR1_OVERFLOW_O
);

  // Registers
  logic [7:0] tmr0_lo_r;
  logic [7:0] tmr0_hi_r;
  logic [7:0] tmr1_lo_r;
  logic [7:0] tmr1_hi_r;
  dlt_tcfg_t cfg0_r;
  dlt_tcfg_t cfg1_r;
  logic clk_sel0_r;
  logic clk_sel1_r;
  dlt_presc_t presc_r;
  logic run0_r;
  logic run1_r;
  logic ovf0_r;
  logic ovf1_r;
  logic ext0_flag_r;
  logic ext1_flag_r;
  logic ext0_type_r;
  logic ext1_type_r;
  logic [7:0] rdata_r;
  logic tmr1_ovf_pulse_r;

  // Decode of writes
  logic wr_ctrl;
  logic wr_mode;
  logic wr_t0l;
  logic wr_t0h;
  logic wr_t1l;
  logic wr_t1h;
  logic wr_cks;

  // Edges and ticks
  logic [4:0] pin_level;
  logic [4:0] pin_fall;
  logic [4:0] pin_rise;
  logic presc_tick;
  logic split;
  logic gate_ok0;
  logic gate_ok1;
  logic tick_clk0;
  logic tick_clk1;
  logic inc0;
  logic inc0_hi;
  logic inc1;
  dlt_cnt_t step0;
  dlt_cnt_t step1;
  logic ovf0_evt;
  logic ovf0_hi_evt;
  logic ovf1_evt;
  logic ovf1_flag_evt;

  assign wr_ctrl = SFR_WR_I & (SFR_ADDR_I == DLT_ADDR_CTRL);
  assign wr_mode = SFR_WR_I & (SFR_ADDR_I == DLT_ADDR_MODE);
  assign wr_t0l = SFR_WR_I & (SFR_ADDR_I == DLT_ADDR_T0_LOW);
  assign wr_t0h = SFR_WR_I & (SFR_ADDR_I == DLT_ADDR_T0_HIGH);
  assign wr_t1l = SFR_WR_I & (SFR_ADDR_I == DLT_ADDR_T1_LOW);
  assign wr_t1h = SFR_WR_I & (SFR_ADDR_I == DLT_ADDR_T1_HIGH);
  assign wr_cks = SFR_WR_I & (SFR_ADDR_I == DLT_ADDR_CLKSEL);

  // Pin edges; a level held for a single clock is enough for its edge to be seen.
  assign pin_level = {EXT_CLK_I, GATE_PIN_ONE_N_I, GATE_PIN_ZERO_N_I,
                      EVENT_PIN_ONE_I, EVENT_PIN_ZERO_I};

  dlt_edge_det #(
    .N(5)
  ) u_edges (
    .clk_i(CLK_SYS_I),
    .reset_i(RESET_I),
    .level_i(pin_level),
    .fall_o(pin_fall),
    .rise_o(pin_rise)
  );

  dlt_prescaler u_presc (
    .clk_i(CLK_SYS_I),
    .reset_i(RESET_I),
    .code_i(presc_r),
    .ext_rise_i(pin_rise[4]),
    .tick_o(presc_tick)
  );

  // One count step for modes 0 to 2, and the low half of split mode.
  function automatic dlt_cnt_t count_step(input dlt_mode_t m, input logic [7:0] hi,
                                          input logic [7:0] lo);
    dlt_cnt_t r;
    logic [13:0] s13;
    logic [16:0] s16;
    r = '{ovf: 1'b0, hi: hi, lo: lo};
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h0_0001;
    case (m)
      DLT_MODE_13BIT: begin
        // The three upper low-byte bits are left alone.
        r.ovf = s13[13];
        r.hi = s13[12:5];
        r.lo = {lo[7:5], s13[4:0]};
      end
      DLT_MODE_16BIT: begin
        r.ovf = s16[16];
        r.hi = s16[15:8];
        r.lo = s16[7:0];
      end
      DLT_MODE_RELOAD: begin
        r.ovf = (lo == 8'hFF);
        r.lo = (lo == 8'hFF) ? hi : lo + 8'h01;
      end
      default: begin
        r.ovf = (lo == 8'hFF);
        r.lo = lo + 8'h01;
      end
    endcase
    return r;
  endfunction

  assign split = (cfg0_r.mode == DLT_MODE_SPLIT);

  assign gate_ok0 = ~cfg0_r.gate | GATE_PIN_ZERO_N_I;
  assign gate_ok1 = ~cfg1_r.gate | GATE_PIN_ONE_N_I;

  assign tick_clk0 = clk_sel0_r | presc_tick;
  assign tick_clk1 = clk_sel1_r | presc_tick;

  // Timer zero, or the low half of split mode, on its own controls.
  assign inc0 = run0_r & gate_ok0 & (cfg0_r.counter_sel ? pin_fall[0] : tick_clk0);

  // The split high half is a clock-only timer run by timer one's run bit.
  assign inc0_hi = split & run1_r & tick_clk0;

  // While split, timer one runs on its mode alone and never counts pin edges.
  // Mode 3 on timer one parks it, split or not.
  always_comb begin
    inc1 = 1'b0;
    if (cfg1_r.mode == DLT_MODE_SPLIT) begin
      inc1 = 1'b0;
    end else if (split) begin
      inc1 = tick_clk1;
    end else begin
      inc1 = run1_r & gate_ok1 & (cfg1_r.counter_sel ? pin_fall[1] : tick_clk1);
    end
  end

  assign step0 = count_step(cfg0_r.mode, tmr0_hi_r, tmr0_lo_r);
  assign step1 = count_step(cfg1_r.mode, tmr1_hi_r, tmr1_lo_r);

  assign ovf0_evt = inc0 & step0.ovf;
  assign ovf0_hi_evt = inc0_hi & (tmr0_hi_r == 8'hFF);
  assign ovf1_evt = inc1 & step1.ovf;
  assign ovf1_flag_evt = split ? ovf0_hi_evt : ovf1_evt;

  // Timer zero counting bytes; a software write beats a count in the same cycle.
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      tmr0_lo_r <= DLT_RESET_BYTE;
      tmr0_hi_r <= DLT_RESET_BYTE;
    end else begin
      if (wr_t0l) begin
        tmr0_lo_r <= SFR_WDATA_I;
      end else if (inc0) begin
        tmr0_lo_r <= step0.lo;
      end
      if (wr_t0h) begin
        tmr0_hi_r <= SFR_WDATA_I;
      end else if (inc0_hi) begin
        tmr0_hi_r <= tmr0_hi_r + 8'h01;
      end else if (inc0 & ~split) begin
        tmr0_hi_r <= step0.hi;
      end
    end
  end

  // Timer one counting bytes.
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      tmr1_lo_r <= DLT_RESET_BYTE;
      tmr1_hi_r <= DLT_RESET_BYTE;
    end else begin
      if (wr_t1l) begin
        tmr1_lo_r <= SFR_WDATA_I;
      end else if (inc1) begin
        tmr1_lo_r <= step1.lo;
      end
      if (wr_t1h) begin
        tmr1_hi_r <= SFR_WDATA_I;
      end else if (inc1) begin
        tmr1_hi_r <= step1.hi;
      end
    end
  end

  // Mode and clock-select registers.
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      cfg0_r <= '0;
      cfg1_r <= '0;
      clk_sel0_r <= 1'b0;
      clk_sel1_r <= 1'b0;
      presc_r <= DLT_PRESC_SYS_12;
    end else begin
      if (wr_mode) begin
        {cfg1_r, cfg0_r} <= SFR_WDATA_I;
      end
      if (wr_cks) begin
        clk_sel1_r <= SFR_WDATA_I[DLT_CKS_CLK1];
        clk_sel0_r <= SFR_WDATA_I[DLT_CKS_CLK0];
        presc_r <= dlt_presc_t'(SFR_WDATA_I[DLT_CKS_PRESC_LSB +: 2]);
      end
    end
  end

  // Run and type bits of timer_control.
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      run0_r <= 1'b0;
      run1_r <= 1'b0;
      ext0_type_r <= 1'b0;
      ext1_type_r <= 1'b0;
    end else if (wr_ctrl) begin
      run1_r <= SFR_WDATA_I[DLT_CTRL_RUN1];
      run0_r <= SFR_WDATA_I[DLT_CTRL_RUN0];
      ext1_type_r <= SFR_WDATA_I[DLT_CTRL_EXT1_TYPE];
      ext0_type_r <= SFR_WDATA_I[DLT_CTRL_EXT0_TYPE];
    end
  end

  // Overflow flags: hardware set wins over a software clear or a vector clear.
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      ovf0_r <= 1'b0;
      ovf1_r <= 1'b0;
    end else begin
      if (ovf0_evt) begin
        ovf0_r <= 1'b1;
      end else if (TMR0_VECTOR_I) begin
        ovf0_r <= 1'b0;
      end else if (wr_ctrl) begin
        ovf0_r <= SFR_WDATA_I[DLT_CTRL_OVF0];
      end
      if (ovf1_flag_evt) begin
        ovf1_r <= 1'b1;
      end else if (TMR1_VECTOR_I) begin
        ovf1_r <= 1'b0;
      end else if (wr_ctrl) begin
        ovf1_r <= SFR_WDATA_I[DLT_CTRL_OVF1];
      end
    end
  end

  // External flags. In level mode the flag tracks the inverted pin, so a clear
  // only sticks once the pin is high again.
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      ext0_flag_r <= 1'b0;
      ext1_flag_r <= 1'b0;
    end else begin
      if (~ext0_type_r) begin
        ext0_flag_r <= ~GATE_PIN_ZERO_N_I;
      end else if (pin_fall[2]) begin
        ext0_flag_r <= 1'b1;
      end else if (EXT0_VECTOR_I) begin
        ext0_flag_r <= 1'b0;
      end else if (wr_ctrl) begin
        ext0_flag_r <= SFR_WDATA_I[DLT_CTRL_EXT0_FLAG];
      end
      if (~ext1_type_r) begin
        ext1_flag_r <= ~GATE_PIN_ONE_N_I;
      end else if (pin_fall[3]) begin
        ext1_flag_r <= 1'b1;
      end else if (EXT1_VECTOR_I) begin
        ext1_flag_r <= 1'b0;
      end else if (wr_ctrl) begin
        ext1_flag_r <= SFR_WDATA_I[DLT_CTRL_EXT1_FLAG];
      end
    end
  end

  // Timer one overflow stays available as a trigger even while split.
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      tmr1_ovf_pulse_r <= 1'b0;
    end else begin
      tmr1_ovf_pulse_r <= ovf1_evt;
    end
  end

  // Read data is registered, so it lags the address by one clock.
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      rdata_r <= DLT_RESET_BYTE;
    end else if (SFR_ADDR_I == DLT_ADDR_CTRL) begin
      rdata_r <= {ovf1_r, run1_r, ovf0_r, run0_r,
                  ext1_flag_r, ext1_type_r, ext0_flag_r, ext0_type_r};
    end else if (SFR_ADDR_I == DLT_ADDR_MODE) begin
      rdata_r <= {cfg1_r, cfg0_r};
    end else if (SFR_ADDR_I == DLT_ADDR_T0_LOW) begin
      rdata_r <= tmr0_lo_r;
    end else if (SFR_ADDR_I == DLT_ADDR_T1_LOW) begin
      rdata_r <= tmr1_lo_r;
    end else if (SFR_ADDR_I == DLT_ADDR_T0_HIGH) begin
      rdata_r <= tmr0_hi_r;
    end else if (SFR_ADDR_I == DLT_ADDR_T1_HIGH) begin
      rdata_r <= tmr1_hi_r;
    end else if (SFR_ADDR_I == DLT_ADDR_CLKSEL) begin
      rdata_r <= {3'b000, clk_sel1_r, clk_sel0_r, 1'b0, presc_r} & DLT_CKS_WR_MASK;
    end else begin
      rdata_r <= DLT_RESET_BYTE;
    end
  end

  assign SFR_RDATA_O = rdata_r;
  assign TMR0_IRQ_O = ovf0_r;
  assign TMR1_IRQ_O = ovf1_r;
  assign EXT0_IRQ_O = ext0_flag_r;
  assign EXT1_IRQ_O = ext1_flag_r;
  assign TMR1_OVERFLOW_O = tmr1_ovf_pulse_r;

endmodule // dlt_timer_pair

/* tb/dlt_timer_pair_assertions.sv */
// Port-level checker for the dual legacy timer pair.
`timescale 1ns/100ps
module dlt_timer_pair_assertions
  import dlt_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  // Register port
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic [7:0] SFR_RDATA_O,
  // Vectors and pins
  input wire logic TMR0_VECTOR_I,
  input wire logic TMR1_VECTOR_I,
  input wire logic EXT1_VECTOR_I,
  input wire logic GATE_PIN_ZERO_N_I,
  input wire logic GATE_PIN_ONE_N_I,
  // Flags
  input wire logic TMR0_IRQ_O,
  input wire logic TMR1_IRQ_O,
  input wire logic EXT0_IRQ_O,
  input wire logic EXT1_IRQ_O,
  input wire logic TMR1_OVERFLOW_O
);
  // Only software writes the run, type, mode and clock bits, so shadows of them are exact.
  logic [3:0] ctl_r;
  logic [7:0] mode_r;
  logic [7:0] cks_r;
  wire wr_ctl = SFR_WR_I && (SFR_ADDR_I == DLT_ADDR_CTRL);
  // Expected control byte, built from the flag outputs and the software-owned shadows.
  wire [7:0] ctl_view = {TMR1_IRQ_O, ctl_r[3], TMR0_IRQ_O, ctl_r[2],
                         EXT1_IRQ_O, ctl_r[1], EXT0_IRQ_O, ctl_r[0]};

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      ctl_r <= 4'h0;
      mode_r <= 8'h00;
      cks_r <= 8'h00;
    end else if (SFR_WR_I) begin
      if (SFR_ADDR_I == DLT_ADDR_CTRL) begin
        ctl_r <= {SFR_WDATA_I[6], SFR_WDATA_I[4], SFR_WDATA_I[2], SFR_WDATA_I[0]};
      end
      if (SFR_ADDR_I == DLT_ADDR_MODE) begin
        mode_r <= SFR_WDATA_I;
      end
      if (SFR_ADDR_I == DLT_ADDR_CLKSEL) begin
        cks_r <= SFR_WDATA_I & DLT_CKS_WR_MASK;
      end
    end
  end

  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);

  AST_CTRL_READ: assert property (
    $past(SFR_ADDR_I) == DLT_ADDR_CTRL |-> SFR_RDATA_O == $past(ctl_view))
    else $error("control register readback wrong");
  AST_MODE_READ: assert property (
    $past(SFR_ADDR_I) == DLT_ADDR_MODE |-> SFR_RDATA_O == $past(mode_r))
    else $error("mode register readback wrong");
  AST_CKS_READ: assert property (
    $past(SFR_ADDR_I) == DLT_ADDR_CLKSEL |-> SFR_RDATA_O == $past(cks_r))
    else $error("clock select readback wrong");
  // A stopped timer cannot overflow, so only the vector and writes move its flag.
  AST_TF0_IDLE: assert property (
    !ctl_r[2] |=> TMR0_IRQ_O == ($past(TMR0_VECTOR_I) ? 1'b0 :
      $past(wr_ctl) ? $past(SFR_WDATA_I[5]) : $past(TMR0_IRQ_O)))
    else $error("timer zero flag moved while stopped");
  AST_TF1_IDLE: assert property (
    !ctl_r[3] |=> TMR1_IRQ_O == ($past(TMR1_VECTOR_I) ? 1'b0 :
      $past(wr_ctl) ? $past(SFR_WDATA_I[7]) : $past(TMR1_IRQ_O)))
    else $error("timer one flag moved while its run bit is clear");
  AST_EXT0_LEVEL: assert property (
    !ctl_r[0] |=> EXT0_IRQ_O == !$past(GATE_PIN_ZERO_N_I))
    else $error("level flag does not follow the inverted pin");
  AST_EXT1_EDGE: assert property (
    ctl_r[1] && $fell(GATE_PIN_ONE_N_I) |=> EXT1_IRQ_O)
    else $error("falling edge did not set the flag");
  AST_EXT1_VEC: assert property (
    ctl_r[1] && EXT1_VECTOR_I && !$fell(GATE_PIN_ONE_N_I) |=> !EXT1_IRQ_O)
    else $error("vector did not clear the edge flag");

  COV_OVF1: cover property ($rose(TMR1_OVERFLOW_O));
  COV_TF0: cover property ($rose(TMR0_IRQ_O));
  COV_EDGE: cover property (ctl_r[1] && $fell(GATE_PIN_ONE_N_I));
endmodule // dlt_timer_pair_assertions

bind dlt_timer_pair dlt_timer_pair_assertions u_dlt_timer_pair_assertions (
  .CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I), .SFR_ADDR_I(SFR_ADDR_I), .SFR_WR_I(SFR_WR_I),
  .SFR_WDATA_I(SFR_WDATA_I), .SFR_RDATA_O(SFR_RDATA_O), .TMR0_VECTOR_I(TMR0_VECTOR_I),
  .TMR1_VECTOR_I(TMR1_VECTOR_I), .EXT1_VECTOR_I(EXT1_VECTOR_I),
  .GATE_PIN_ZERO_N_I(GATE_PIN_ZERO_N_I), .GATE_PIN_ONE_N_I(GATE_PIN_ONE_N_I),
  .TMR0_IRQ_O(TMR0_IRQ_O), .TMR1_IRQ_O(TMR1_IRQ_O), .EXT0_IRQ_O(EXT0_IRQ_O),
  .EXT1_IRQ_O(EXT1_IRQ_O), .TMR1_OVERFLOW_O(TMR1_OVERFLOW_O)
);

/* tb/dlt_pin_model.sv */
// Model of the event pins, gate pins and external oscillator facing the timer pair.
`timescale 1ns/100ps
module dlt_pin_model (
  // Clock
  input wire logic clk_i,
  // Pins
  output logic [1:0] event_o,
  output logic [1:0] gate_n_o,
  output logic ext_clk_o
);
  // Each pin has a single owner; its idle level is given where it is declared.
  logic [1:0] event_r = 2'h3;
  logic [1:0] gate_n_r = 2'h3;
  logic ext_clk_r = 1'b0;
  logic [1:0] ext_cnt_r = 2'h0;

  assign event_o = event_r;
  assign gate_n_o = gate_n_r;
  assign ext_clk_o = ext_clk_r;

  // The oscillator runs free with a period of six clocks, so each level lasts three.
  always @(posedge clk_i) begin
    ext_cnt_r <= (ext_cnt_r == 2'h2) ? 2'h0 : ext_cnt_r + 2'h1;
    if (ext_cnt_r == 2'h2) begin
      ext_clk_r <= ~ext_clk_r;
    end
  end

  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge clk_i);
      event_r[idx] <= 1'b0;
      repeat (2) @(posedge clk_i);
      event_r[idx] <= 1'b1;
      @(posedge clk_i);
    end
  endtask

  task automatic set_gate(input int idx, input logic lvl);
    @(posedge clk_i);
    gate_n_r[idx] <= lvl;
    repeat (2) @(posedge clk_i);
  endtask
endmodule // dlt_pin_model

/* tb/dlt_timer_pair_tb_top.sv */
// Self-checking testbench for the dual legacy timer pair.
`timescale 1ns/100ps
module dlt_timer_pair_tb_top
  import dlt_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [3:0] vec = 4'h0;
  logic [7:0] rdata;
  logic [1:0] ev;
  logic [1:0] gn;
  logic xclk;
  logic [3:0] irq;
  logic ovf1;
  int num_errors = 0;
  int checks_done = 0;
  int g;
  logic [7:0] regs [8] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h8F};
  logic [7:0] cks_tab [5] = '{8'h10, 8'h00, 8'h01, 8'h02, 8'h03};
  logic [7:0] gap_tab [5] = '{8'h01, 8'h0C, 8'h04, 8'h30, 8'h30};

  always #5 clk = ~clk;

  dlt_timer_pair u_dlt_timer_pair (
    .CLK_SYS_I(clk), .RESET_I(rst), .SFR_ADDR_I(addr), .SFR_WR_I(wr), .SFR_WDATA_I(wdata),
    .SFR_RDATA_O(rdata), .TMR0_VECTOR_I(vec[0]), .TMR1_VECTOR_I(vec[1]),
    .EXT0_VECTOR_I(vec[2]), .EXT1_VECTOR_I(vec[3]), .EVENT_PIN_ZERO_I(ev[0]),
    .EVENT_PIN_ONE_I(ev[1]), .GATE_PIN_ZERO_N_I(gn[0]), .GATE_PIN_ONE_N_I(gn[1]),
    .EXT_CLK_I(xclk), .TMR0_IRQ_O(irq[0]), .TMR1_IRQ_O(irq[1]), .EXT0_IRQ_O(irq[2]),
    .EXT1_IRQ_O(irq[3]), .TMR1_OVERFLOW_O(ovf1)
  );

  dlt_pin_model u_dlt_pin_model (.clk_i(clk), .event_o(ev), .gate_n_o(gn), .ext_clk_o(xclk));

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    #1 chk(rdata, exp);
  endtask

  task automatic vec_pulse(input logic [3:0] m);
    @(posedge clk);
    vec <= m;
    @(posedge clk);
    vec <= 4'h0;
  endtask

  // Waits for a flag or pulse under a bound; running out ends the run.
  task automatic wait_hi(input int i, input int lim, output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while ((i == 4 ? ovf1 : irq[i]) !== 1'b1 && k < lim);
    if (k >= lim) begin
      num_errors++;
      $display("[FAIL] %0t wait ran out", $time);
      print_verdict();
    end
  endtask

  // The divider runs free, so only the third gap is trusted.
  task automatic gap(output int n);
    repeat (3) wait_hi(4, 100, n);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (regs[i]) rd_chk(regs[i], 8'h00);
    wr_reg(DLT_ADDR_CLKSEL, 8'hFF);
    rd_chk(DLT_ADDR_CLKSEL, DLT_CKS_WR_MASK);
    wr_reg(DLT_ADDR_MODE, 8'hA5);
    rd_chk(DLT_ADDR_MODE, 8'hA5);
    // Timer one reloads FF each tick, so pulse spacing equals the prescaled period.
    wr_reg(DLT_ADDR_MODE, 8'h20);
    wr_reg(DLT_ADDR_T1_HIGH, 8'hFF);
    wr_reg(DLT_ADDR_T1_LOW, 8'hFF);
    wr_reg(DLT_ADDR_CTRL, 8'h40);
    for (int i = 0; i < 5; i++) begin
      wr_reg(DLT_ADDR_CLKSEL, cks_tab[i]);
      gap(g);
      chk(8'(g), gap_tab[i]);
    end
    wr_reg(DLT_ADDR_MODE, 8'h30);
    wr_reg(DLT_ADDR_CTRL, 8'h00);
    rd_chk(DLT_ADDR_T1_LOW, 8'hFF);
    // Thirteen-bit counting of pin events with the gate; upper low-byte bits are kept.
    wr_reg(DLT_ADDR_T0_HIGH, 8'hFF);
    wr_reg(DLT_ADDR_T0_LOW, 8'h3E);
    wr_reg(DLT_ADDR_MODE, 8'h3C);
    wr_reg(DLT_ADDR_CTRL, 8'h10);
    u_dlt_pin_model.pulse(0, 2);
    rd_chk(DLT_ADDR_T0_LOW, 8'h20);
    rd_chk(DLT_ADDR_T0_HIGH, 8'h00);
    chk({7'h0, irq[0]}, 8'h01);
    u_dlt_pin_model.set_gate(0, 1'b0);
    #1 chk({7'h0, irq[2]}, 8'h01);
    u_dlt_pin_model.pulse(0, 3);
    rd_chk(DLT_ADDR_T0_LOW, 8'h20);
    u_dlt_pin_model.set_gate(0, 1'b1);
    vec_pulse(4'h1);
    #1 chk({7'h0, irq[0]}, 8'h00);
    // Split mode: timer one free-runs without its flag, the high byte takes it over.
    wr_reg(DLT_ADDR_CLKSEL, 8'h18);
    wr_reg(DLT_ADDR_T0_LOW, 8'hFE);
    wr_reg(DLT_ADDR_T0_HIGH, 8'hF0);
    wr_reg(DLT_ADDR_MODE, 8'h67);
    gap(g);
    chk(8'(g), 8'h01);
    chk({7'h0, irq[1]}, 8'h00);
    wr_reg(DLT_ADDR_MODE, 8'h77);
    repeat (2) @(posedge clk);
    repeat (20) begin
      @(posedge clk);
      #1 chk({7'h0, ovf1}, 8'h00);
    end
    wr_reg(DLT_ADDR_CTRL, 8'h10);
    u_dlt_pin_model.pulse(0, 3);
    rd_chk(DLT_ADDR_T0_LOW, 8'h01);
    rd_chk(DLT_ADDR_T0_HIGH, 8'hF0);
    chk({7'h0, irq[0]}, 8'h01);
    wr_reg(DLT_ADDR_CTRL, 8'h50);
    wait_hi(1, 40, g);
    chk({7'h0, irq[1]}, 8'h01);
    vec_pulse(4'h2);
    #1 chk({7'h0, irq[1]}, 8'h00);
    // External flag one in falling-edge mode.
    wr_reg(DLT_ADDR_CTRL, 8'h04);
    u_dlt_pin_model.set_gate(1, 1'b0);
    #1 chk({7'h0, irq[3]}, 8'h01);
    u_dlt_pin_model.set_gate(1, 1'b1);
    #1 chk({7'h0, irq[3]}, 8'h01);
    vec_pulse(4'h8);
    #1 chk({7'h0, irq[3]}, 8'h00);
    // Sixteen-bit counting of timer one pin events, wrapping through zero.
    wr_reg(DLT_ADDR_T1_HIGH, 8'hFF);
    wr_reg(DLT_ADDR_T1_LOW, 8'hFE);
    wr_reg(DLT_ADDR_MODE, 8'h50);
    wr_reg(DLT_ADDR_CTRL, 8'h44);
    u_dlt_pin_model.pulse(1, 3);
    rd_chk(DLT_ADDR_T1_LOW, 8'h01);
    rd_chk(DLT_ADDR_T1_HIGH, 8'h00);
    chk({7'h0, irq[1]}, 8'h01);
    // External flag zero in falling-edge mode, cleared by its vector while the pin stays low.
    wr_reg(DLT_ADDR_CTRL, 8'h01);
    u_dlt_pin_model.set_gate(0, 1'b0);
    #1 chk({7'h0, irq[2]}, 8'h01);
    vec_pulse(4'h4);
    #1 chk({7'h0, irq[2]}, 8'h00);
    u_dlt_pin_model.set_gate(0, 1'b1);
    print_verdict();
  end
endmodule // dlt_timer_pair_tb_top
